// ==== rtl/bst_engine.sv ====
// Purpose: bus test-and-set semaphore engine with a swap unit beside it
// Assumes: bus slaves answer each strobe with ack or err, then drop it
// Notes: one request at a time; result holds from done to next start
// a start during the done cycle is already taken as a request
// Summary of operation
// RULE_01 - test-and-set writes 1, returns old value
// RULE_02 - old value 1 means semaphore not claimed
// RULE_03 - acquired only when old value was 0
// RULE_04 - release is a plain write of 0
// RULE_05 - bus locked across read and write
// RULE_06 - byte and halfword; odd halfword gives 7
// RULE_07 - absolute address is base plus offset
// RULE_08 - subslot defaults 0, region defaults 1
// RULE_09 - status codes 0 through 5
// RULE_10 - status codes 6, 8, 9, 10
// RULE_11 - status 0 means bus completed only
// RULE_12 - completion ok when enabled without error
// RULE_13 - swap bytes in word, halves in dword
// RULE_14 - swap applied per element over length
// RULE_15 - host words little-endian, low byte first
// RULE_16 - bus lanes pass bytes with no reordering
// RULE_17 - host swaps words for big-endian modules
// RULE_18 - host also reverses multiword order
// RULE_19 - swap input and output share one type
// RULE_20 - start/done handshake, result held till start
`timescale 1ns/1ps
module bst_engine (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic start,
  input wire bst_pkg::bst_req_type request,
  output logic busy,
  output logic done,
  output bst_pkg::bst_result_type result,
  input wire logic cfgWrite,
  input wire logic [bst_pkg::IDX_W-1:0] cfgIndex,
  input wire bst_pkg::bst_cfg_type cfgData,
  output logic busLock,
  output logic busStrobe,
  output logic busWrite,
  output logic busHalfword,
  output logic [bst_pkg::ADDR_W-1:0] busAddr,
  output logic [15:0] busWrData,
  input wire logic [15:0] busRdData,
  input wire logic busAck,
  input wire logic busErr,
  input wire logic swapStart,
  input wire logic [bst_pkg::LEN_W-1:0] swapLength,
  input wire logic swapDword,
  input wire logic swapInValid,
  input wire logic [bst_pkg::DATA_W-1:0] swapInData,
  output logic swapOutValid,
  output logic [bst_pkg::DATA_W-1:0] swapOutData,
  output logic swapBusy,
  output logic swapDone
);

  // check state gives the table read a cycle to settle
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_CHECK = 3'b001,
    S_READ = 3'b010,
    S_WRITE = 3'b011,
    S_FINISH = 3'b100
  } bst_state_type;

  // sequencer, request and result registers
  bst_state_type state_q, state_d;
  bst_pkg::bst_req_type req_q, req_d;
  bst_pkg::bst_result_type res_q, res_d;
  logic done_q, done_d;
  // bus side registers; all but oldValue_q drive an output
  logic lock_q, lock_d;
  logic strobe_q, strobe_d;
  logic write_q, write_d;
  logic [bst_pkg::ADDR_W-1:0] addr_q, addr_d;
  logic [15:0] wrData_q, wrData_d;
  logic [15:0] oldValue_q, oldValue_d;

  // configuration table, one entry per slot and region
  bst_pkg::bst_cfg_type cfgMem [bst_pkg::CFG_DEPTH];
  logic [bst_pkg::CFG_DEPTH-1:0] cfgValid_q, cfgValid_d;
  // table lookup and the check results
  logic [bst_pkg::IDX_W-1:0] lookIdx;
  bst_pkg::bst_cfg_type lookCfg;
  logic [bst_pkg::ADDR_W-1:0] absAddr;
  logic [bst_pkg::STAT_W-1:0] checkStatus;

  // old value seen on the lanes the access used
  function automatic logic semaFree(
    input logic halfword,
    input logic [15:0] d
  );
    if (halfword) begin
      semaFree = (d == bst_pkg::SEMA_FREE);
    end else begin
      semaFree = (d[7:0] == bst_pkg::SEMA_FREE[7:0]);
    end
  endfunction

  // table entries carry no reset; a valid bit per entry guards them
  always_ff @(posedge clk_sys) begin
    if (cfgWrite) begin
      cfgMem[cfgIndex] <= cfgData;
    end
  end

  // an entry counts as present only once the host has written it
  always_comb begin
    cfgValid_d = cfgValid_q;
    if (cfgWrite) begin
      cfgValid_d[cfgIndex] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cfgValid_q <= '0;
    end else begin
      cfgValid_q <= cfgValid_d;
    end
  end

  // table index is the registered slot and region
  assign lookIdx = {req_q.slot, req_q.regionSelect};
  assign lookCfg = cfgMem[lookIdx];

  // checks run on the registered request
  bst_check u_check (
    .req(req_q),
    .cfg(lookCfg),
    .cfgValid(cfgValid_q[lookIdx]),
    .absAddr(absAddr),
    .checkStatus(checkStatus)
  );

  // request sequencer; strobe drops for a cycle between read and write
  always_comb begin
    state_d = state_q;
    req_d = req_q;
    res_d = res_q;
    done_d = 1'b0;
    lock_d = lock_q;
    strobe_d = strobe_q;
    write_d = write_q;
    addr_d = addr_q;
    wrData_d = wrData_q;
    oldValue_d = oldValue_q;
    unique case (state_q)
      // idle: take a request, fill in left-out fields
      S_IDLE: begin
        if (start) begin // RULE_20
          req_d = request;
          if (!request.subslotGiven) begin
            req_d.subslot = bst_pkg::SUBSLOT_DEFAULT; // RULE_08
          end
          if (!request.regionGiven) begin
            req_d.regionSelect = bst_pkg::REGION_DEFAULT; // RULE_08
          end
          res_d = '0;
          state_d = S_CHECK;
        end
      end

      // one cycle for the table read and the checks
      S_CHECK: begin
        if (checkStatus != bst_pkg::ST_OK) begin
          res_d.statusCode = checkStatus; // RULE_06
          state_d = S_FINISH;
        end else begin
          addr_d = absAddr; // RULE_07
          // lock rises with the read strobe
          lock_d = 1'b1; // RULE_05
          strobe_d = 1'b1;
          write_d = 1'b0;
          state_d = S_READ;
        end
      end

      // locked read fetches the old value
      S_READ: begin
        // an error ends it here; no write follows
        if (busErr) begin
          strobe_d = 1'b0;
          lock_d = 1'b0;
          res_d.statusCode = bst_pkg::ST_BUS_ERR; // RULE_09
          state_d = S_FINISH;
        end else if (busAck) begin
          oldValue_d = busRdData; // RULE_16
          strobe_d = 1'b0;
          write_d = 1'b1;
          wrData_d = bst_pkg::SEMA_SET; // RULE_01 RULE_04
          state_d = S_WRITE; // lock stays high: RULE_05
        end
      end

      // strobe drops a cycle so the slave can drop its ack
      S_WRITE: begin
        if (!strobe_q) begin
          strobe_d = 1'b1;
        end else if (busErr || busAck) begin
          // write answered: unlock and record the result
          strobe_d = 1'b0;
          write_d = 1'b0;
          lock_d = 1'b0; // RULE_05
          state_d = S_FINISH;
          if (busErr) begin
            res_d.statusCode = bst_pkg::ST_BUS_ERR; // RULE_09
          end else begin
            res_d.statusCode = bst_pkg::ST_OK; // RULE_11
            // old 1 keeps it owned elsewhere, old 0 is ours
            res_d.acquired =
                semaFree(req_q.halfword, oldValue_q); // RULE_02 RULE_03
            res_d.opOk = 1'b1; // RULE_12
          end
        end
      end

      // result is in place; pulse done for one cycle
      S_FINISH: begin
        done_d = 1'b1; // RULE_20
        state_d = S_IDLE;
      end
    endcase
  end

  // sequencer state and bus output flops
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q <= S_IDLE;
      req_q <= '0;
      res_q <= '0;
      done_q <= 1'b0;
      lock_q <= 1'b0;
      strobe_q <= 1'b0;
      write_q <= 1'b0;
      addr_q <= 32'h0000_0000;
      wrData_q <= 16'h0000;
      oldValue_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      req_q <= req_d;
      res_q <= res_d;
      done_q <= done_d;
      lock_q <= lock_d;
      strobe_q <= strobe_d;
      write_q <= write_d;
      addr_q <= addr_d;
      wrData_q <= wrData_d;
      oldValue_q <= oldValue_d;
    end
  end

  // busy and width follow the next state, so they rise with the
  // accepting edge; registering them keeps the outputs glitch free
  logic busy_q, busy_d;
  logic half_q, half_d;

  always_comb begin
    busy_d = (state_d != S_IDLE); // RULE_20
    half_d = req_d.halfword; // RULE_06
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      busy_q <= 1'b0;
      half_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
      half_q <= half_d;
    end
  end

  // outputs come straight from flops
  assign busy = busy_q;
  assign done = done_q;
  assign result = res_q;
  assign busLock = lock_q;
  assign busStrobe = strobe_q;
  assign busWrite = write_q;
  assign busHalfword = half_q;
  assign busAddr = addr_q;
  // bytes go out on their own lanes, never reordered: RULE_16
  assign busWrData = wrData_q; // RULE_15 RULE_16

  // swap unit for host data exchanged with big-endian modules
  bst_swap u_swap (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .swapStart(swapStart),
    .swapLength(swapLength),
    .swapDword(swapDword),
    .inValid(swapInValid),
    .inData(swapInData),
    .outValid(swapOutValid),
    .outData(swapOutData),
    .swapBusy(swapBusy),
    .swapDone(swapDone)
  );

endmodule // bst_engine

// ==== include/bst_pkg.sv ====
// Purpose: shared constants and carriers for the semaphore engine
// Assumes: one 50 MHz clock, plain ports, no register bus
// Notes: status codes, field widths and fixed bus values live here
package bst_pkg;

  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned RACK_W = 4;
  localparam int unsigned SLOT_W = 4;
  localparam int unsigned SUB_W = 4;
  localparam int unsigned RGN_W = 3;
  localparam int unsigned IDX_W = SLOT_W + RGN_W;
  localparam int unsigned CFG_DEPTH = 1 << IDX_W;
  localparam int unsigned STAT_W = 4;
  localparam int unsigned LEN_W = 16;

  // request defaults for left-out fields, the only rack accepted and the refused region
  localparam logic [SUB_W-1:0] SUBSLOT_DEFAULT = 4'h0;
  localparam logic [RGN_W-1:0] REGION_DEFAULT = 3'h1;
  localparam logic [RACK_W-1:0] RACK_MAIN = 4'h0;
  localparam logic [RGN_W-1:0] REGION_NONE = 3'h0;

  // semaphore values on the bus
  localparam logic [15:0] SEMA_SET = 16'h0001;
  localparam logic [15:0] SEMA_FREE = 16'h0000;

  // byte counts of an access, less one, for the end address check
  localparam logic [ADDR_W-1:0] BYTE_SPAN = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] WORD_SPAN = 32'h0000_0001;

  // status codes
  localparam logic [STAT_W-1:0] ST_OK = 4'h0;
  localparam logic [STAT_W-1:0] ST_BUS_ERR = 4'h1;
  localparam logic [STAT_W-1:0] ST_NO_MODULE = 4'h2;
  localparam logic [STAT_W-1:0] ST_BAD_TYPE = 4'h3;
  localparam logic [STAT_W-1:0] ST_START_RANGE = 4'h4;
  localparam logic [STAT_W-1:0] ST_END_RANGE = 4'h5;
  localparam logic [STAT_W-1:0] ST_ODD_ONLY = 4'h6;
  localparam logic [STAT_W-1:0] ST_MISALIGN = 4'h7;
  localparam logic [STAT_W-1:0] ST_RGN_OFF = 4'h8;
  localparam logic [STAT_W-1:0] ST_TOO_WIDE = 4'h9;
  localparam logic [STAT_W-1:0] ST_BAD_PARAM = 4'hA;

  // one test-and-set request from the host
  typedef struct packed {
    logic [RACK_W-1:0] rack;
    logic [SLOT_W-1:0] slot;
    logic [SUB_W-1:0] subslot;
    logic subslotGiven;
    logic [RGN_W-1:0] regionSelect;
    logic regionGiven;
    logic [ADDR_W-1:0] offset;
    logic halfword; // halfword_semaphore_variant when set
  } bst_req_type;

  // configuration of one module region
  typedef struct packed {
    logic present;
    logic typeOk;
    logic enabled;
    logic oddOnly;
    logic byteOnly;
    logic [ADDR_W-1:0] base;
    logic [ADDR_W-1:0] size;
  } bst_cfg_type;

  // engine result held until the next start
  typedef struct packed {
    logic [STAT_W-1:0] statusCode;
    logic acquired;
    logic opOk;
  } bst_result_type;

endpackage : bst_pkg

// ==== rtl/bst_check.sv ====
// Purpose: validates a request and forms its absolute bus address
// Assumes: request and configuration entry are stable while checked
// Notes: purely combinational; first failing check gives the status
`timescale 1ns/1ps
module bst_check (
  input wire bst_pkg::bst_req_type req,
  input wire bst_pkg::bst_cfg_type cfg,
  input wire logic cfgValid,
  output logic [bst_pkg::ADDR_W-1:0] absAddr,
  output logic [bst_pkg::STAT_W-1:0] checkStatus
);

  logic [bst_pkg::ADDR_W-1:0] span;
  logic [bst_pkg::ADDR_W-1:0] lastOff;

  // absolute address is base plus byte offset
  assign absAddr = cfg.base + req.offset; // RULE_07
  assign span = req.halfword ? bst_pkg::WORD_SPAN : bst_pkg::BYTE_SPAN;
  assign lastOff = req.offset + span;

  // order of checks: parameters, module, region, range, width, alignment
  always_comb begin
    checkStatus = bst_pkg::ST_OK;
    if (req.rack != bst_pkg::RACK_MAIN ||
        req.regionSelect == bst_pkg::REGION_NONE) begin
      checkStatus = bst_pkg::ST_BAD_PARAM; // RULE_10
    end else if (!cfgValid || !cfg.present) begin
      checkStatus = bst_pkg::ST_NO_MODULE; // RULE_09
    end else if (!cfg.typeOk) begin
      checkStatus = bst_pkg::ST_BAD_TYPE; // RULE_09
    end else if (!cfg.enabled) begin
      checkStatus = bst_pkg::ST_RGN_OFF; // RULE_10
    end else if (req.offset >= cfg.size) begin
      checkStatus = bst_pkg::ST_START_RANGE; // RULE_09
    end else if (lastOff >= cfg.size || lastOff < req.offset) begin
      checkStatus = bst_pkg::ST_END_RANGE; // RULE_09
    end else if (req.halfword && cfg.byteOnly) begin
      checkStatus = bst_pkg::ST_TOO_WIDE; // RULE_10
    end else if (req.halfword && absAddr[0]) begin
      checkStatus = bst_pkg::ST_MISALIGN; // RULE_06
    end else if (cfg.oddOnly && !absAddr[0]) begin
      checkStatus = bst_pkg::ST_ODD_ONLY; // RULE_10
    end
  end

endmodule // bst_check

// ==== rtl/bst_swap.sv ====
// Purpose: byte swap in words or half swap in doublewords over a length
// Assumes: one element offered per inValid pulse after swapStart
// Notes: mode is latched at start so input and output share one type
`timescale 1ns/1ps
module bst_swap (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic swapStart,
  input wire logic [bst_pkg::LEN_W-1:0] swapLength,
  input wire logic swapDword,
  input wire logic inValid,
  input wire logic [bst_pkg::DATA_W-1:0] inData,
  output logic outValid,
  output logic [bst_pkg::DATA_W-1:0] outData,
  output logic swapBusy,
  output logic swapDone
);

  logic modeDword_q, modeDword_d;
  logic busy_q, busy_d;
  logic [bst_pkg::LEN_W-1:0] left_q, left_d;
  logic valid_q, valid_d;
  logic [bst_pkg::DATA_W-1:0] data_q, data_d;
  logic done_q, done_d;

  // one element swapped according to the latched type
  function automatic logic [bst_pkg::DATA_W-1:0] swapElem(
    input logic dword,
    input logic [bst_pkg::DATA_W-1:0] d
  );
    if (dword) begin
      swapElem = {d[15:0], d[31:16]}; // RULE_13
    end else begin
      swapElem = {16'h0000, d[7:0], d[15:8]}; // RULE_13
    end
  endfunction

  // element counter; a zero length finishes at once
  always_comb begin
    modeDword_d = modeDword_q;
    busy_d = busy_q;
    left_d = left_q;
    valid_d = 1'b0;
    data_d = data_q;
    done_d = 1'b0;
    if (swapStart && !busy_q) begin
      modeDword_d = swapDword; // RULE_19
      left_d = swapLength;
      busy_d = (swapLength != 16'h0000);
      done_d = (swapLength == 16'h0000);
    end else if (busy_q && inValid) begin
      valid_d = 1'b1;
      data_d = swapElem(modeDword_q, inData); // RULE_14
      left_d = left_q - 16'h0001;
      if (left_q == 16'h0001) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      modeDword_q <= 1'b0;
      busy_q <= 1'b0;
      left_q <= 16'h0000;
      valid_q <= 1'b0;
      data_q <= 32'h0000_0000;
      done_q <= 1'b0;
    end else begin
      modeDword_q <= modeDword_d;
      busy_q <= busy_d;
      left_q <= left_d;
      valid_q <= valid_d;
      data_q <= data_d;
      done_q <= done_d;
    end
  end

  assign outValid = valid_q;
  assign outData = data_q;
  assign swapBusy = busy_q;
  assign swapDone = done_q;

endmodule // bst_swap

// ==== bench/bst_engine_assertions.sv ====
// Purpose: temporal checks on the semaphore engine ports
// Assumes: single clock domain, reset active low
// Notes: old semaphore value is captured from the read answer
`timescale 1ns/1ps
module bst_engine_assertions (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic start,
  input wire logic busy,
  input wire logic done,
  input wire bst_pkg::bst_result_type result,
  input wire logic busLock,
  input wire logic busStrobe,
  input wire logic busWrite,
  input wire logic busHalfword,
  input wire logic [bst_pkg::ADDR_W-1:0] busAddr,
  input wire logic [15:0] busWrData,
  input wire logic [15:0] busRdData,
  input wire logic busAck,
  input wire logic busErr
);
  logic oldZero_q;
  logic oldZero_d;
  // byte semaphores only look at the low lane
  always_comb begin
    oldZero_d = oldZero_q;
    if (busStrobe && !busWrite && busAck)
      oldZero_d = busHalfword ? busRdData == 16'h0000 : busRdData[7:0] == 8'h00;
  end
  // register the captured flag
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) oldZero_q <= 1'h0;
    else oldZero_q <= oldZero_d;
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  AST_WRITE_ONE: assert property (
    busStrobe && busWrite |-> busWrData == bst_pkg::SEMA_SET)
    else $error("set write does not carry one");
  AST_ACQ_OLD: assert property (
    done |-> result.acquired == (result.statusCode == 4'h0 && oldZero_q))
    else $error("acquired flag does not follow old value");
  AST_LOCK_SPAN: assert property (
    busStrobe && !busWrite && busAck |=> busLock [*2])
    else $error("lock dropped between read and write");
  AST_STROBE_LOCKED: assert property (
    busStrobe |-> busLock)
    else $error("bus access without lock");
  AST_READ_ERR_STOP: assert property (
    busStrobe && !busWrite && busErr |=> !busStrobe [*3])
    else $error("write issued after read error");
  AST_OK_FLAG: assert property (
    done |-> result.opOk == (result.statusCode == 4'h0))
    else $error("completion flag disagrees with status");
  AST_HALF_ALIGN: assert property (
    busStrobe && busHalfword |-> !busAddr[0])
    else $error("odd halfword address on bus");
  AST_STROBE_HOLD: assert property (
    busStrobe && !busAck && !busErr |=> busStrobe && $stable(busAddr))
    else $error("strobe or address moved before answer");
  AST_DONE_PULSE: assert property (
    done |=> !done)
    else $error("done longer than one cycle");
  AST_START_ANSWER: assert property (
    start && !busy && !done |=> busy ##[1:60] done)
    else $error("accepted start not answered");
  AST_RESULT_HOLD: assert property (
    !busy && !start |=> $stable(result))
    else $error("result changed while idle");
  cover property (done && result.acquired);
  cover property (done && result.statusCode == bst_pkg::ST_BUS_ERR);
  cover property (busStrobe && busWrite && busAck);
endmodule // bst_engine_assertions

bind bst_engine bst_engine_assertions chkInst (
  .clk_sys(clk_sys), .resetn(resetn), .start(start), .busy(busy),
  .done(done), .result(result), .busLock(busLock), .busStrobe(busStrobe),
  .busWrite(busWrite), .busHalfword(busHalfword), .busAddr(busAddr),
  .busWrData(busWrData), .busRdData(busRdData), .busAck(busAck),
  .busErr(busErr));

// ==== bench/bst_slave_model.sv ====
// Purpose: bus slave holding semaphore words for the engine bench
// Assumes: one answer per strobe, dropped once strobe drops
// Notes: wait and error behaviour are set by the bench
`timescale 1ns/1ps
module bst_slave_model (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic busStrobe,
  input wire logic busWrite,
  input wire logic busHalfword,
  input wire logic [31:0] busAddr,
  input wire logic [15:0] busWrData,
  input wire logic [3:0] waitCycles,
  input wire logic [1:0] errMode,
  output logic [15:0] busRdData,
  output logic busAck,
  output logic busErr
);
  logic [15:0] sem [0:255];
  logic [31:0] lastAddr;
  logic [3:0] cnt;
  logic [7:0] idx;
  assign idx = busAddr[7:0];
  // answer after the set wait; stale data toggles so it cannot pass
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      busAck <= 1'h0;
      busErr <= 1'h0;
      cnt <= 4'h0;
      busRdData <= 16'hFFFF;
    end else if (busStrobe && !busAck && !busErr) begin
      if (cnt < waitCycles) begin
        cnt <= cnt + 4'h1;
      end else if (busWrite ? errMode[1] : errMode[0]) begin
        busErr <= 1'h1;
      end else begin
        busAck <= 1'h1;
        lastAddr <= busAddr;
        busRdData <= sem[idx];
        if (busWrite)
          sem[idx] <= busHalfword ? busWrData
                                  : {sem[idx][15:8], busWrData[7:0]};
      end
    end else begin
      if (!busStrobe) begin
        busAck <= 1'h0;
        busErr <= 1'h0;
        cnt <= 4'h0;
      end
      if (!busAck) busRdData <= ~busRdData;
    end
  end
endmodule // bst_slave_model

// ==== bench/bst_engine_tb.sv ====
// Purpose: self-checking bench for the semaphore engine
// Assumes: slave model answers the bus side
// Notes: drivers queue expectations, a monitor compares them
`timescale 1ns/1ps
module bst_engine_tb;
  logic clk_sys = 1'h0;
  logic resetn = 1'h0;
  logic start = 1'h0;
  logic cfgWrite = 1'h0;
  logic swapStart = 1'h0;
  logic swapDword = 1'h0;
  logic swapInValid = 1'h0;
  logic [6:0] cfgIndex = 7'h00;
  logic [15:0] swapLength = 16'h0000;
  logic [31:0] swapInData = 32'h0000_0000;
  logic [3:0] waitCycles = 4'h0;
  logic [1:0] errMode = 2'h0;
  bst_pkg::bst_req_type request = '0;
  bst_pkg::bst_cfg_type cfgData = '0;
  bst_pkg::bst_result_type result, mExp;
  logic busy, done, busLock, busStrobe, busWrite, busHalfword, busAck, busErr;
  logic swapOutValid, swapBusy, swapDone;
  logic [31:0] busAddr, swapOutData;
  logic [15:0] busWrData, busRdData;
  bst_pkg::bst_result_type expQ[$];
  logic [31:0] swapQ[$];
  int numErrors = 0;
  int checkCount = 0;
  always #10 clk_sys = ~clk_sys;
  bst_engine DUT (
    .clk_sys(clk_sys), .resetn(resetn), .start(start), .request(request),
    .busy(busy), .done(done), .result(result), .cfgWrite(cfgWrite),
    .cfgIndex(cfgIndex), .cfgData(cfgData), .busLock(busLock),
    .busStrobe(busStrobe), .busWrite(busWrite), .busHalfword(busHalfword),
    .busAddr(busAddr), .busWrData(busWrData), .busRdData(busRdData),
    .busAck(busAck), .busErr(busErr), .swapStart(swapStart),
    .swapLength(swapLength), .swapDword(swapDword),
    .swapInValid(swapInValid), .swapInData(swapInData),
    .swapOutValid(swapOutValid), .swapOutData(swapOutData),
    .swapBusy(swapBusy), .swapDone(swapDone));
  bst_slave_model slave (
    .clk_sys(clk_sys), .resetn(resetn), .busStrobe(busStrobe),
    .busWrite(busWrite), .busHalfword(busHalfword), .busAddr(busAddr),
    .busWrData(busWrData), .waitCycles(waitCycles), .errMode(errMode),
    .busRdData(busRdData), .busAck(busAck), .busErr(busErr));
  // count every compare, report each mismatch
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checkCount++;
    if (exp !== got) begin
      numErrors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // print counts and the verdict, then stop
  task automatic testDone();
    $display("checks %0d mismatches %0d", checkCount, numErrors);
    if (numErrors == 0 && checkCount > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // compare each finished request and swapped element with its note
  always @(posedge clk_sys) begin
    if (done === 1'h1) begin
      if (expQ.size() == 0) chk("spareDone", 32'h0, 32'h1);
      else begin
        mExp = expQ.pop_front();
        chk("status", mExp.statusCode, result.statusCode);
        chk("acquired", mExp.acquired, result.acquired);
        chk("opOk", mExp.opOk, result.opOk);
      end
    end
    if (swapOutValid === 1'h1) begin
      if (swapQ.size() == 0) chk("spareSwap", 32'h0, 32'h1);
      else chk("swapData", swapQ.pop_front(), swapOutData);
    end
  end
  // load one region-1 entry: base 0x1000, 256 bytes long
  task automatic cfg(logic [3:0] sl, logic [4:0] fl);
    @(posedge clk_sys);
    cfgWrite <= 1'h1;
    cfgIndex <= {sl, 3'h1};
    cfgData <= {fl, 32'h0000_1000, 32'h0000_0100};
    @(posedge clk_sys);
    cfgWrite <= 1'h0;
  endtask
  // start held two edges so the second one must be refused
  task automatic tas(logic [3:0] rk, logic [3:0] sl, logic [2:0] rg,
      logic [31:0] off, logic hw, logic [3:0] st, logic acq);
    bst_pkg::bst_result_type e;
    logic rgOn;
    int n;
    e = '{st, acq, st == 4'h0};
    rgOn = (rg != 3'h1) | 1'($urandom);
    expQ.push_back(e);
    @(posedge clk_sys);
    request <= '{rk, sl, 4'($urandom), 1'($urandom),
      rgOn ? rg : 3'($urandom), rgOn, off, hw};
    start <= 1'h1;
    repeat (2) @(posedge clk_sys);
    start <= 1'h0;
    for (n = 0; n < 80 && done !== 1'h1; n++) @(posedge clk_sys);
    if (done !== 1'h1) chk("done", 32'h1, 32'h0);
    if (st == 4'h0) chk("addr", 32'h1000 + off, slave.lastAddr);
    if (st == 4'h0) chk("sem", 32'h1, slave.sem[off[7:0]][7:0]);
  endtask
  // one swap run, expected element queued before it is offered
  task automatic swp(logic dw, logic [3:0] len);
    logic [31:0] d;
    int n;
    @(posedge clk_sys);
    swapStart <= 1'h1;
    swapLength <= {12'h000, len};
    swapDword <= dw;
    @(posedge clk_sys);
    swapStart <= 1'h0;
    for (n = 0; n < len; n++) begin
      if (n == 1) chk("swapBusy", 32'h1, swapBusy);
      d = $urandom;
      swapQ.push_back(dw ? {d[15:0], d[31:16]} : {16'h0, d[7:0], d[15:8]});
      swapInValid <= 1'h1;
      swapInData <= d;
      @(posedge clk_sys);
    end
    swapInValid <= 1'h0;
    for (n = 0; n < 20 && swapDone !== 1'h1; n++) @(posedge clk_sys);
    if (swapDone !== 1'h1) chk("swapDone", 32'h1, 32'h0);
    chk("swapIdle", 32'h0, swapBusy);
  endtask
  // main sequence: refusals first, then bus traffic, then swaps
  initial begin
    logic [31:0] off;
    logic [15:0] v;
    int i;
    void'($urandom(98));
    repeat (2) @(posedge clk_sys);
    resetn <= 1'h1;
    cfg(4'h4, 5'h1C);
    cfg(4'h5, 5'h14);
    cfg(4'h6, 5'h18);
    cfg(4'h7, 5'h1E);
    cfg(4'h8, 5'h1D);
    tas(4'h1, 4'h4, 3'h1, 32'h0, 1'h0, 4'hA, 1'h0);
    tas(4'h0, 4'h4, 3'h0, 32'h0, 1'h0, 4'hA, 1'h0);
    tas(4'h0, 4'h9, 3'h1, 32'h0, 1'h0, 4'h2, 1'h0);
    tas(4'h0, 4'h5, 3'h1, 32'h0, 1'h0, 4'h3, 1'h0);
    tas(4'h0, 4'h6, 3'h1, 32'h0, 1'h0, 4'h8, 1'h0);
    tas(4'h0, 4'h4, 3'h1, 32'h100, 1'h0, 4'h4, 1'h0);
    tas(4'h0, 4'h4, 3'h1, 32'hFF, 1'h1, 4'h5, 1'h0);
    tas(4'h0, 4'h4, 3'h1, 32'h3, 1'h1, 4'h7, 1'h0);
    tas(4'h0, 4'h7, 3'h1, 32'h2, 1'h0, 4'h6, 1'h0);
    tas(4'h0, 4'h8, 3'h1, 32'h0, 1'h1, 4'h9, 1'h0);
    slave.sem[2] = 16'h0000;
    tas(4'h0, 4'h4, 3'h1, 32'h2, 1'h1, 4'h0, 1'h1);
    tas(4'h0, 4'h4, 3'h1, 32'h2, 1'h1, 4'h0, 1'h0);
    slave.sem[2] = 16'h0000;
    tas(4'h0, 4'h4, 3'h1, 32'h2, 1'h1, 4'h0, 1'h1);
    slave.sem[5] = 16'hA500;
    tas(4'h0, 4'h4, 3'h1, 32'h5, 1'h0, 4'h0, 1'h1);
    slave.sem[6] = 16'h0100;
    tas(4'h0, 4'h4, 3'h1, 32'h6, 1'h1, 4'h0, 1'h0);
    errMode <= 2'h1;
    tas(4'h0, 4'h4, 3'h1, 32'h8, 1'h1, 4'h1, 1'h0);
    errMode <= 2'h2;
    slave.sem[8] = 16'h0000;
    tas(4'h0, 4'h4, 3'h1, 32'h8, 1'h1, 4'h1, 1'h0);
    errMode <= 2'h0;
    for (i = 0; i < 8; i++) begin
      v = 16'($urandom_range(0, 1));
      off = {24'h0, 7'($urandom), 1'h0};
      slave.sem[off[7:0]] = v;
      waitCycles <= 4'($urandom_range(0, 6));
      tas(4'h0, 4'h4, 3'h1, off, 1'($urandom), 4'h0, v == 16'h0);
    end
    swp(1'h0, 4'h3);
    swp(1'h1, 4'h4);
    swp(1'h0, 4'h0);
    repeat (3) @(posedge clk_sys);
    chk("leftOver", 32'h0, expQ.size() + swapQ.size());
    testDone();
  end
  // cut a hang short, far beyond the expected run length
  initial begin
    #200000;
    numErrors++;
    testDone();
  end
endmodule // bst_engine_tb
